// ---- core/fdcrm_regs.vh ----
// Constants of the floppy controller host register and mode block.
// Assumes inclusion by the single core design file.
`ifndef FDCRM_REGS_VH
`define FDCRM_REGS_VH

// Operations register fields
`define FDCRM_OP_DRIVE_CHOICE_BIT 0
`define FDCRM_OP_SPARE1 1
`define FDCRM_OP_SOFT_RESET_N 2
`define FDCRM_OP_DMA_IRQ_QUALIFY 3
`define FDCRM_OP_MOTOR_ONE_ENABLE 4
`define FDCRM_OP_MOTOR_TWO_ENABLE 5
`define FDCRM_OP_MODE_CHOICE_BIT 7
`define FDCRM_OP_RESET 8'h00

// Status two fields
`define FDCRM_S2_MD 0
`define FDCRM_S2_BC 1
`define FDCRM_S2_SN 2
`define FDCRM_S2_SH 3
`define FDCRM_S2_WC 4
`define FDCRM_S2_DD 5
`define FDCRM_S2_CM 6

// Modes
`define FDCRM_MODE_RESET 2'h0
`define FDCRM_MODE_BASE 2'h1
`define FDCRM_MODE_SPECIAL 2'h2
`define FDCRM_MODE_COMPAT 2'h3

// All ones cylinder value
`define FDCRM_CYL_ALL_ONES 8'hff

`endif

// ---- core/fdcrm_core.v ----
// Host register decode, status two and three, operations register, modes.
// Assumes host strobes and drive inputs are asynchronous and are
// synchronised here; sequencer events come from logic on mclk.
`timescale 1ns/10ps
`include "fdcrm_regs.vh"

// ==========================================================
// Two flip-flop synchroniser
module fdcrm_sync (
   input wire mclk,
   input wire sys_rst,
   input wire d,
   output reg q
);
   reg meta_q;
   // First stage read only by the second
   always @(posedge mclk) begin
      if (sys_rst) begin
         meta_q <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // fdcrm_sync

// ==========================================================
// Top level
module fdcrm_core (
   input wire mclk,
   input wire sys_rst,
   input wire cs_n,
   input wire a0,
   input wire rd_n,
   input wire wr_n,
   input wire op_register_load_strobe_n,
   input wire ctrl_register_load_strobe_n,
   input wire [7:0] db_in,
   output reg [7:0] db_out,
   output wire db_oe,
   input wire [7:0] main_status,
   input wire [7:0] data_to_host,
   output reg [7:0] data_from_host,
   output reg data_from_host_stb,
   output reg data_to_host_stb,
   input wire [1:0] stat_sel,
   input wire ev_deleted_mark,
   input wire ev_data_crc_bad,
   input wire ev_id_compare,
   input wire [7:0] medium_cylinder,
   input wire [7:0] id_compare_register,
   input wire ev_scan_equal,
   input wire ev_scan_unmet,
   input wire ev_data_mark_missing,
   input wire status_clear,
   input wire write_protect_in,
   input wire track_zero_in,
   input wire head_side_state,
   input wire unit_bit_one,
   input wire unit_bit_zero,
   input wire fdc_drq,
   input wire fdc_irq,
   input wire dack_n,
   output wire dma_req,
   output wire dma_req_oe,
   output wire irq_req,
   output wire irq_req_oe,
   output wire dack_q_n,
   output reg drive_one_select_n,
   output reg drive_two_select_n,
   output reg drive_three_select_n,
   output reg drive_four_select_n,
   output reg motor_one_on_n,
   output reg motor_two_on_n,
   output wire ctrl_soft_reset,
   output wire ctrl_timers_keep
);
   wire cs_s_n;
   wire a0_s;
   wire rd_s_n;
   wire wr_s_n;
   wire op_register_load_strobe_s_n;
   wire ctrl_register_load_strobe_s_n;
   wire wp_s;
   wire tz_s;
   wire dack_s_n;
   reg [7:0] db_s1_q;
   reg [7:0] db_s2_q;
   reg rd_prev_q;
   reg wr_prev_q;
   reg ctrl_register_load_strobe_prev_q;
   reg [7:0] op_q;
   reg [1:0] mode_q;
   reg [6:0] st2_q;
   reg [7:0] st2_d;
   reg drive_oe_q;
   reg rd_active;
   wire rd_any;
   wire wr_any;
   wire rd_fall;
   wire wr_fall;
   wire ctrl_register_load_strobe_rd;
   wire host_access;
   wire ld_op;
   wire cyl_mismatch;
   wire op_used;
   wire soft_rst_active;
   wire [7:0] st3;

   // Synchronise asynchronous pins
   fdcrm_sync u_cs (.mclk(mclk), .sys_rst(sys_rst), .d(~cs_n), .q(cs_s_n));
   fdcrm_sync u_a0 (.mclk(mclk), .sys_rst(sys_rst), .d(a0), .q(a0_s));
   fdcrm_sync u_rd (.mclk(mclk), .sys_rst(sys_rst), .d(~rd_n), .q(rd_s_n));
   fdcrm_sync u_wr (.mclk(mclk), .sys_rst(sys_rst), .d(~wr_n), .q(wr_s_n));
   fdcrm_sync u_lo (.mclk(mclk), .sys_rst(sys_rst),
      .d(~op_register_load_strobe_n), .q(op_register_load_strobe_s_n));
   fdcrm_sync u_lc (.mclk(mclk), .sys_rst(sys_rst),
      .d(~ctrl_register_load_strobe_n), .q(ctrl_register_load_strobe_s_n));
   fdcrm_sync u_wp (.mclk(mclk), .sys_rst(sys_rst), .d(write_protect_in),
      .q(wp_s));
   fdcrm_sync u_tz (.mclk(mclk), .sys_rst(sys_rst), .d(track_zero_in),
      .q(tz_s));
   fdcrm_sync u_dk (.mclk(mclk), .sys_rst(sys_rst), .d(~dack_n),
      .q(dack_s_n));

   // Data bus synchroniser
   always @(posedge mclk) begin
      if (sys_rst) begin
         db_s1_q <= 8'h00;
         db_s2_q <= 8'h00;
      end else begin
         db_s1_q <= db_in;
         db_s2_q <= db_s1_q;
      end
   end

   // Synchronised outputs are active-high copies of the active-low pins
   wire cs_act = cs_s_n;
   wire rd_act = rd_s_n;
   wire wr_act = wr_s_n;
   wire op_register_load_strobe_act = op_register_load_strobe_s_n;
   wire ctrl_register_load_strobe_act = ctrl_register_load_strobe_s_n;

   // Legal chip accesses only; both strobes together is refused
   assign rd_any = cs_act & rd_act & ~wr_act;
   assign wr_any = cs_act & wr_act & ~rd_act & a0_s;
   assign ctrl_register_load_strobe_rd = ctrl_register_load_strobe_act & rd_act & ~wr_act & ~cs_act;
   assign ld_op = op_register_load_strobe_act & wr_act & ~rd_act & ~cs_act;

   // Edge detect on strobes
   always @(posedge mclk) begin
      if (sys_rst) begin
         rd_prev_q <= 1'b0;
         wr_prev_q <= 1'b0;
         ctrl_register_load_strobe_prev_q <= 1'b0;
      end else begin
         rd_prev_q <= rd_any;
         wr_prev_q <= wr_any | ld_op;
         ctrl_register_load_strobe_prev_q <= ctrl_register_load_strobe_rd;
      end
   end
   assign rd_fall = rd_any & ~rd_prev_q;
   assign wr_fall = (wr_any | ld_op) & ~wr_prev_q;
   assign host_access = rd_fall | (wr_any & ~wr_prev_q);

   // Operations register is only honoured in special and compatible modes
   assign op_used = (mode_q == `FDCRM_MODE_SPECIAL) |
                    (mode_q == `FDCRM_MODE_COMPAT);

   // Operations register load
   always @(posedge mclk) begin
      if (sys_rst) begin
         op_q <= `FDCRM_OP_RESET;
      end else if (ld_op & wr_fall) begin
         op_q <= db_s2_q;
      end
   end

   // Mode sequencing
   always @(posedge mclk) begin
      if (sys_rst) begin
         mode_q <= `FDCRM_MODE_RESET;
      end else begin
         case (mode_q)
            `FDCRM_MODE_RESET: begin
               if (ld_op & wr_fall)
                  mode_q <= `FDCRM_MODE_COMPAT;
               else if (host_access)
                  mode_q <= `FDCRM_MODE_BASE;
            end
            `FDCRM_MODE_BASE: begin
               if (ld_op & wr_fall)
                  mode_q <= `FDCRM_MODE_COMPAT;
            end
            `FDCRM_MODE_SPECIAL,
            `FDCRM_MODE_COMPAT: begin
               // Pattern with motors off and soft reset low, then control read
               if (ctrl_register_load_strobe_rd & ~ctrl_register_load_strobe_prev_q & ~op_q[`FDCRM_OP_SOFT_RESET_N] &
                   ~op_q[`FDCRM_OP_MOTOR_ONE_ENABLE] & ~op_q[`FDCRM_OP_MOTOR_TWO_ENABLE])
                  mode_q <= op_q[`FDCRM_OP_MODE_CHOICE_BIT] ?
                            `FDCRM_MODE_SPECIAL : `FDCRM_MODE_COMPAT;
            end
            default: mode_q <= `FDCRM_MODE_RESET;
         endcase
      end
   end

   // Soft reset: held after hardware reset, off in base mode, else from bit two
   assign soft_rst_active = (mode_q == `FDCRM_MODE_RESET) |
                            (op_used & ~op_q[`FDCRM_OP_SOFT_RESET_N]);
   assign ctrl_soft_reset = soft_rst_active;
   // Timers survive soft reset; only hardware reset clears them
   assign ctrl_timers_keep = ~sys_rst;

   // Request outputs: tristated until first access, qualified by DMA enable in special and compatible modes
   always @(posedge mclk) begin
      if (sys_rst)
         drive_oe_q <= 1'b0;
      else
         drive_oe_q <= (mode_q != `FDCRM_MODE_RESET);
   end
   assign dma_req = fdc_drq & (~op_used | op_q[`FDCRM_OP_DMA_IRQ_QUALIFY]);
   assign irq_req = fdc_irq & (~op_used | op_q[`FDCRM_OP_DMA_IRQ_QUALIFY]);
   assign dack_q_n = ~(dack_s_n & (~op_used | op_q[`FDCRM_OP_DMA_IRQ_QUALIFY]));
   assign dma_req_oe = drive_oe_q;
   assign irq_req_oe = drive_oe_q;

   // Cylinder comparison for the ID check
   assign cyl_mismatch = ev_id_compare &
                         (medium_cylinder != id_compare_register);

   // Status two flags, set wins over clear
   always @* begin
      st2_d = {1'b0, status_clear ? 7'h00 : st2_q};
      if (ev_deleted_mark)
         st2_d[`FDCRM_S2_CM] = 1'b1;
      if (ev_data_crc_bad)
         st2_d[`FDCRM_S2_DD] = 1'b1;
      if (cyl_mismatch)
         st2_d[`FDCRM_S2_WC] = 1'b1;
      if (ev_scan_equal)
         st2_d[`FDCRM_S2_SH] = 1'b1;
      if (ev_scan_unmet)
         st2_d[`FDCRM_S2_SN] = 1'b1;
      if (cyl_mismatch & (medium_cylinder == `FDCRM_CYL_ALL_ONES))
         st2_d[`FDCRM_S2_BC] = 1'b1;
      if (ev_data_mark_missing)
         st2_d[`FDCRM_S2_MD] = 1'b1;
   end
   always @(posedge mclk) begin
      if (sys_rst | soft_rst_active)
         st2_q <= 7'h00;
      else
         st2_q <= st2_d[6:0];
   end

   // Status three from live drive state
   assign st3 = {1'b0, wp_s, 1'b1, tz_s, wp_s, head_side_state,
                 unit_bit_one, unit_bit_zero};

   // Read data mux, registered
   always @(posedge mclk) begin
      if (sys_rst) begin
         db_out <= 8'h00;
         rd_active <= 1'b0;
      end else begin
         rd_active <= rd_any;
         if (rd_any & ~a0_s)
            db_out <= main_status;
         else if (rd_any & (stat_sel == 2'h2))
            db_out <= {1'b0, st2_q};
         else if (rd_any & (stat_sel == 2'h3))
            db_out <= st3;
         else if (rd_any)
            db_out <= data_to_host;
      end
   end
   assign db_oe = rd_active & rd_any;

   // Data port write and read strobes to the sequencer
   always @(posedge mclk) begin
      if (sys_rst) begin
         data_from_host <= 8'h00;
         data_from_host_stb <= 1'b0;
         data_to_host_stb <= 1'b0;
      end else begin
         data_from_host_stb <= wr_any & ~wr_prev_q;
         data_to_host_stb <= rd_fall & a0_s;
         if (wr_any & ~wr_prev_q)
            data_from_host <= db_s2_q;
      end
   end

   // Drive select and motor outputs
   always @(posedge mclk) begin
      if (sys_rst) begin
         drive_one_select_n <= 1'b1;
         drive_two_select_n <= 1'b1;
         drive_three_select_n <= 1'b1;
         drive_four_select_n <= 1'b1;
         motor_one_on_n <= 1'b1;
         motor_two_on_n <= 1'b1;
      end else if (mode_q == `FDCRM_MODE_COMPAT) begin
         // Bit one must be zero for either select
         drive_one_select_n <= ~(~op_q[`FDCRM_OP_DRIVE_CHOICE_BIT] &
            op_q[`FDCRM_OP_MOTOR_ONE_ENABLE] & ~op_q[`FDCRM_OP_SPARE1]);
         drive_two_select_n <= ~(op_q[`FDCRM_OP_DRIVE_CHOICE_BIT] &
            op_q[`FDCRM_OP_MOTOR_TWO_ENABLE] & ~op_q[`FDCRM_OP_SPARE1]);
         drive_three_select_n <= 1'b1;
         drive_four_select_n <= 1'b1;
         motor_one_on_n <= ~op_q[`FDCRM_OP_MOTOR_ONE_ENABLE];
         motor_two_on_n <= ~op_q[`FDCRM_OP_MOTOR_TWO_ENABLE];
      end else begin
         // One-of-four decode of the unit select bits
         drive_one_select_n <= ~(~unit_bit_one & ~unit_bit_zero);
         drive_two_select_n <= ~(~unit_bit_one & unit_bit_zero);
         drive_three_select_n <= ~(unit_bit_one & ~unit_bit_zero);
         drive_four_select_n <= ~(unit_bit_one & unit_bit_zero);
         motor_one_on_n <= 1'b1;
         motor_two_on_n <= 1'b1;
      end
   end
endmodule // fdcrm_core

// ---- bench/fdcrm_assertions.sv ----
// Port checker for the host register and mode block.
// Assumes a bind onto fdcrm_core; sees only its ports.
`timescale 1ns/10ps
// ==========================================================
// Checker
module fdcrm_chk (
   input wire mclk,
   input wire sys_rst,
   input wire a0,
   input wire rd_n,
   input wire wr_n,
   input wire op_register_load_strobe_n,
   input wire [7:0] db_in,
   input wire db_oe,
   input wire data_from_host_stb,
   input wire fdc_drq,
   input wire fdc_irq,
   input wire dma_req,
   input wire dma_req_oe,
   input wire irq_req,
   input wire irq_req_oe,
   input wire drive_one_select_n,
   input wire drive_two_select_n,
   input wire drive_three_select_n,
   input wire drive_four_select_n,
   input wire motor_one_on_n,
   input wire ctrl_soft_reset
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // Host port decode and bus drive
   a_read_drive: assert property (
      $rose(db_oe) |-> !$past(rd_n, 2) && !rd_n) else $error("bus drive");
   a_read_release: assert property (
      $rose(rd_n) |-> ##[1:3] !db_oe) else $error("bus not released");
   a_write_quiet: assert property (
      !wr_n [*3] |-> !db_oe) else $error("bus driven in write");
   a_write_pulse: assert property (
      data_from_host_stb |-> a0 && !wr_n ##1 !data_from_host_stb)
      else $error("bad write pulse");
   // Reset state, modes and drive outputs
   a_reset_outs: assert property (
      $fell(sys_rst) |-> ctrl_soft_reset && !dma_req_oe && !irq_req_oe)
      else $error("bad reset state");
   a_one_select: assert property (
      !drive_one_select_n |-> drive_two_select_n && drive_three_select_n
      && drive_four_select_n) else $error("two drives selected");
   a_motor_load: assert property (
      $fell(motor_one_on_n) |-> !$past(op_register_load_strobe_n)
      && !$past(wr_n) && $past(db_in[4])) else $error("motor on");
   a_soft_load: assert property (
      $rose(ctrl_soft_reset) |-> !$past(op_register_load_strobe_n)
      && !$past(db_in[2])) else $error("soft reset entry");
   a_dma_gate: assert property (
      dma_req |-> fdc_drq) else $error("dma request");
   a_irq_gate: assert property (
      irq_req |-> fdc_irq) else $error("irq request");
   // Main scenarios seen
   c_read: cover property ($rose(db_oe));
   c_write: cover property (data_from_host_stb);
   c_motor: cover property ($fell(motor_one_on_n));
   c_soft: cover property ($rose(ctrl_soft_reset));
endmodule // fdcrm_chk

bind fdcrm_core fdcrm_chk u_chk (.*);

// ---- bench/fdcrm_host.sv ----
// Host bus model: drives strobes, address and data pins.
// Assumes the bench calls cyc from a clocked sequence.
`timescale 1ns/10ps
// ==========================================================
// Host model
module fdcrm_host (
   input wire mclk,
   input wire [7:0] db_out,
   input wire db_oe,
   output reg cs_n,
   output reg a0,
   output reg rd_n,
   output reg wr_n,
   output reg op_register_load_strobe_n,
   output reg ctrl_register_load_strobe_n,
   output reg [7:0] db_in
);
   // Idle pins at time zero
   initial begin
      {cs_n, a0, rd_n, wr_n} = 4'hb;
      {op_register_load_strobe_n, ctrl_register_load_strobe_n} = 2'h3;
      db_in = 8'h00;
   end
   // One access: held five edges, then four idle edges
   task cyc(input [5:0] s, input [7:0] d, output [7:0] q, output oe);
      integer i;
      begin
         oe = 1'b0;
         q = 8'h00;
         @(posedge mclk);
         {cs_n, a0, rd_n, wr_n, op_register_load_strobe_n,
            ctrl_register_load_strobe_n} <= s;
         db_in <= d;
         for (i = 0; i < 5; i = i + 1) begin
            @(posedge mclk);
            if (db_oe === 1'b1) begin
               oe = 1'b1;
               q = db_out;
            end
         end
         {cs_n, rd_n, wr_n} <= 3'h7;
         {op_register_load_strobe_n, ctrl_register_load_strobe_n} <= 2'h3;
         db_in <= ~d;
         repeat (4) @(posedge mclk);
      end
   endtask
endmodule // fdcrm_host

// ---- bench/fdcrm_bench.sv ----
// Self-checking bench for the host register and mode block.
// Assumes the host model and the checker compile before it.
`timescale 1ns/10ps
// ==========================================================
// Bench top
module fdcrm_bench;
   typedef struct packed {
      logic [5:0] ev;
      logic [7:0] med;
      logic [7:0] exp;
   } fdcrm_row_t;
   localparam [5:0] p_msr = 6'h07, p_drd = 6'h17, p_dwr = 6'h1b;
   localparam [5:0] p_bad = 6'h0b, p_opw = 6'h39, p_crd = 6'h36;
   localparam [5:0] p_both = 6'h23;
   reg mclk = 1'b0, sys_rst = 1'b1, status_clear = 1'b0;
   reg write_protect_in = 1'b0, track_zero_in = 1'b0;
   reg head_side_state = 1'b0, unit_bit_one = 1'b0, unit_bit_zero = 1'b0;
   reg fdc_drq = 1'b0, fdc_irq = 1'b1, dack_n = 1'b0;
   reg [1:0] stat_sel = 2'h2;
   reg [5:0] ev = 6'h00;
   reg [7:0] medium_cylinder = 8'h21, id_compare_register = 8'h21;
   reg [7:0] main_status = 8'h5a, data_to_host = 8'hc3;
   reg [7:0] q, wcnt = 8'h00, rcnt = 8'h00;
   reg oe;
   integer i, mismatches = 0, compares = 0;
   wire cs_n, a0, rd_n, wr_n, op_register_load_strobe_n, db_oe;
   wire ctrl_register_load_strobe_n, data_from_host_stb, data_to_host_stb;
   wire ev_deleted_mark, ev_data_crc_bad, ev_id_compare, ev_scan_equal;
   wire ev_scan_unmet, ev_data_mark_missing, dma_req, dma_req_oe;
   wire irq_req, irq_req_oe, dack_q_n, ctrl_soft_reset, ctrl_timers_keep;
   wire drive_one_select_n, drive_two_select_n, drive_three_select_n;
   wire drive_four_select_n, motor_one_on_n, motor_two_on_n;
   wire [7:0] db_in, db_out, data_from_host;
   wire [7:0] pins = {drive_four_select_n, drive_three_select_n,
      drive_two_select_n, drive_one_select_n, motor_two_on_n,
      motor_one_on_n, ctrl_soft_reset, dma_req};
   wire [7:0] gates = {5'h00, dack_q_n, irq_req, irq_req_oe};
   fdcrm_row_t rows [0:7] = '{'{6'h01, 8'h21, 8'h40},
      '{6'h02, 8'h21, 8'h20}, '{6'h04, 8'h22, 8'h10},
      '{6'h08, 8'h21, 8'h08}, '{6'h10, 8'h21, 8'h04},
      '{6'h04, 8'hff, 8'h12}, '{6'h20, 8'h21, 8'h01},
      '{6'h04, 8'h21, 8'h00}};
   // Sequencer event pulses
   assign {ev_data_mark_missing, ev_scan_unmet, ev_scan_equal,
      ev_id_compare, ev_data_crc_bad, ev_deleted_mark} = ev;
   fdcrm_core dut (.*);
   fdcrm_host host (.*);
   // Clock and data port write and read pulse counts
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      if (data_from_host_stb === 1'b1) wcnt <= wcnt + 8'h01;
      if (data_to_host_stb === 1'b1) rcnt <= rcnt + 8'h01;
   end
   // ==========================================================
   // Tasks
   task chk(input [7:0] got, input [7:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
         end
      end
   endtask
   task end_of_test;
      begin
         if (mismatches == 0 && compares > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task st3(input [4:0] in, input [7:0] exp);
      begin
         {write_protect_in, track_zero_in, head_side_state, unit_bit_one,
            unit_bit_zero} <= in;
         repeat (4) @(posedge mclk);
         host.cyc(p_drd, 8'h00, q, oe);
         chk(q, exp);
      end
   endtask
   task opw(input [7:0] d, input [7:0] exp);
      begin
         host.cyc(p_opw, d, q, oe);
         chk(pins, exp);
      end
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      {unit_bit_one, unit_bit_zero} <= 2'h2;
      repeat (2) @(posedge mclk);
      chk(pins, 8'hbe);
      chk({7'h00, dma_req_oe}, 8'h00);
      fdc_drq <= 1'b1;
      host.cyc(p_msr, 8'h00, q, oe);
      chk(q, 8'h5a);
      chk(pins, 8'hbd);
      chk({7'h00, dma_req_oe}, 8'h01);
      chk(gates, 8'h03);
      for (i = 0; i < 8; i = i + 1) begin
         medium_cylinder <= rows[i].med;
         status_clear <= 1'b1;
         @(posedge mclk);
         status_clear <= 1'b0;
         ev <= rows[i].ev;
         @(posedge mclk);
         ev <= 6'h00;
         host.cyc(p_drd, 8'h00, q, oe);
         chk(q, rows[i].exp);
      end
      stat_sel <= 2'h3;
      st3(5'h16, 8'h6e);
      st3(5'h09, 8'h31);
      stat_sel <= 2'h0;
      host.cyc(p_drd, 8'h00, q, oe);
      chk(q, 8'hc3);
      host.cyc(p_dwr, 8'ha5, q, oe);
      chk(data_from_host, 8'ha5);
      host.cyc(p_bad, 8'h3c, q, oe);
      chk({7'h00, oe}, 8'h00);
      chk(data_from_host, 8'ha5);
      host.cyc(p_both, 8'h5c, q, oe);
      chk({7'h00, oe}, 8'h00);
      chk(data_from_host, 8'ha5);
      chk(wcnt, 8'h01);
      chk(rcnt, 8'h0b);
      opw(8'h1c, 8'he9);
      opw(8'h14, 8'he8);
      chk(gates, 8'h05);
      opw(8'h2d, 8'hd5);
      opw(8'h2f, 8'hf5);
      opw(8'h80, 8'hfe);
      chk({7'h00, ctrl_timers_keep}, 8'h01);
      host.cyc(p_crd, 8'h00, q, oe);
      opw(8'h8c, 8'hdd);
      // Flag event and clear in one cycle: the set wins
      stat_sel <= 2'h2;
      status_clear <= 1'b1;
      ev <= 6'h01;
      @(posedge mclk);
      status_clear <= 1'b0;
      ev <= 6'h00;
      host.cyc(p_drd, 8'h00, q, oe);
      chk(q, 8'h40);
      end_of_test;
   end
   // Hang limit
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches = mismatches + 1;
      end_of_test;
   end
endmodule // fdcrm_bench
